// ### test_tpw_router.sv
// self-checking bench for the timer event router over every mode.
// assumes the core model answers vector requests with a random delay.
module test_tpw_router;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0, vreq_d = 0;
   logic [7:0] awaddr = 0, araddr = 0, en;
   logic [31:0] wdata = 0, rdata, rd;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, rs, slow = 0;
   logic [4:0] tev = 0;
   logic wake, nxt, vreq, vack, orun, mrun, prun;
   logic [9:0] vaddr;
   logic [11:0] exp_q[$];
   int n_errors = 0, tests_run = 0;
   localparam logic [9:0] VEC [5] = '{
      10'h018,
      10'h01b,
      10'h01e,
      10'h012,
      10'h015};
   always #2.5 aclk = ~aclk;
   tpw_router DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .timer_event(tev), .wake_core(wake),
      .next_instr_pulse(nxt), .vector_req(vreq), .vector_addr(vaddr),
      .vector_ack(vack), .osc_run(orun), .main_counters_run(mrun),
      .pulse_gen_run(prun));
   tpw_core_model u_core (.aclk(aclk), .aresetn(aresetn),
      .vector_req(vreq), .slow(slow), .vector_ack(vack));
   // ==========================================================
   // shared tasks
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // write: address and data offered together, each dropped when taken
   // no cycle limit here: a slave that never answers is ended by the watchdog
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      {awvalid, wvalid, bready} <= 3'h7;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      chk(bresp, 2'h0);
   endtask
   task automatic rdreg(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      rd = rdata;
      rs = rresp;
   endtask
   task automatic take(input logic [11:0] g);
      chk(g, exp_q.size() ? exp_q.pop_front() : 12'hfff);
   endtask
   // ==========================================================
   // monitor: any wake, next or vector result must match the oldest note
   always @(posedge aclk) begin
      vreq_d <= vreq;
      if (aresetn && wake) take({2'h3, 10'h0});
      if (aresetn && nxt) take({2'h1, 10'h0});
      if (aresetn && vreq && !vreq_d) take({2'h2, vaddr});
   end
   initial begin
      repeat (20000) @(posedge aclk);
      n_errors++;
      close_out();
   end
   // ==========================================================
   // main sequence: reset values, then every source, mode and global enable, with random source enables
   initial begin
      void'($urandom(32'h611117ee));
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      for (int a = 0; a < 4; a++) begin
         rdreg(8'(a * 4));
         chk(rd, 32'h0);
      end
      rdreg(8'h10);
      chk(rs, 2'h2);
      $display("test registers done");
      for (int m = 0; m < 4; m++) begin
         for (int i = 0; i < 5; i++) begin
            for (int g = 0; g < 2; g++) begin
               en = 8'($urandom) & 8'hf8;
               slow <= 2'($urandom);
               wr(8'h00, {24'h0, en});
               wr(8'h08, 32'(m * 2 + g));
               if (en[i + 3] && m != 3) begin
                  if (m == 2) exp_q.push_back({2'h3, 10'h0});
                  if (g) exp_q.push_back({2'h2, VEC[i]});
                  else exp_q.push_back({2'h1, 10'h0});
               end
               @(posedge aclk);
               tev[i] <= 1'b1;
               repeat (3) @(posedge aclk);
               tev[i] <= 1'b0;
               repeat (12) @(posedge aclk);
               chk({orun, mrun, prun}, (m != 3) ? 32'h7 : 32'h0);
               rdreg(8'h04);
               chk(rd, (en[i + 3] && m != 3) ? 32'h8 << i : 32'h0);
               wr(8'h04, 32'hf8);
            end
         end
         $display("test mode %0d done", m);
      end
      repeat (5) @(posedge aclk);
      chk(exp_q.size(), 32'h0);
      close_out();
   end
endmodule // test_tpw_router

// ### tpw_core_model.sv
// core sequencer stand-in: takes each vector request after a set delay.
// assumes vector_req stays up until vector_ack is sampled high.
module tpw_core_model (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       vector_req,
   input  wire logic [1:0] slow,
   output logic            vector_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] wait_cnt;
   // ==========================================================
   // ack slow + 1 cycles after the request; the ack lasts one cycle so that a held
   // request is never taken twice
   always @(posedge aclk) begin
      if (!aresetn || !vector_req || vector_ack) begin
         vector_ack <= 1'b0;
         wait_cnt   <= 2'h0;
      end else if (wait_cnt == slow) begin
         vector_ack <= 1'b1;
      end else begin
         wait_cnt <= wait_cnt + 2'h1;
      end
   end
endmodule // tpw_core_model

// ### tpw_defs.vh
// register offsets, field positions, reset values and vectors for the
// timer-source interrupt and wake-up router.
// assumes a 32-bit axi4-lite slave with one aligned word per register.
`ifndef TPW_DEFS_VH
`define TPW_DEFS_VH

// ==========================================================
// register byte addresses
`define TPW_ADDR_ENABLE   8'h00
`define TPW_ADDR_PENDING  8'h04
`define TPW_ADDR_CONTROL  8'h08
`define TPW_ADDR_STATUS   8'h0c

// ==========================================================
// enable and pending bit positions
`define TPW_BIT_CNT_A     3
`define TPW_BIT_CNT_B     4
`define TPW_BIT_CNT_C     5
`define TPW_BIT_HIGH      6
`define TPW_BIT_LOW       7
`define TPW_SRC_MASK      8'hf8

// ==========================================================
// control register fields
`define TPW_CTL_GIE       0
`define TPW_CTL_MODE_LSB  1
`define TPW_CTL_MODE_MSB  2

// ==========================================================
// power modes
`define TPW_MODE_NORMAL   2'h0
`define TPW_MODE_GREEN    2'h1
`define TPW_MODE_IDLE     2'h2
`define TPW_MODE_SLEEP    2'h3

// ==========================================================
// vectors and reset values
`define TPW_VEC_HIGH      10'h012
`define TPW_VEC_LOW       10'h015
`define TPW_VEC_CNT_A     10'h018
`define TPW_VEC_CNT_B     10'h01b
`define TPW_VEC_CNT_C     10'h01e
`define TPW_RST_ENABLE    8'h00
`define TPW_RST_PENDING   8'h00
`define TPW_RST_CONTROL   3'h0

`endif

// ### tpw_router.v
// interrupt and wake-up router for five timer event sources.
// assumes event inputs are levels from the timer domain, edge detected here,
// and a core sequencer that takes vector_req with vector_ack.
//
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`include "tpw_defs.vh"

module tpw_router (
   input  wire        aclk,
   input  wire        aresetn,
   // axi4-lite slave
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // timer events: {low, high, counter c, counter b, counter a}
   input  wire [4:0]  timer_event,
   // core sequencer side
   output reg         wake_core,
   output reg         next_instr_pulse,
   output reg         vector_req,
   output reg  [9:0]  vector_addr,
   input  wire        vector_ack,
   output reg         osc_run,
   output reg         main_counters_run,
   output reg         pulse_gen_run
);
   // ==========================================================
   // registers and wires
   reg  [7:0]  timer_source_interrupt_enable;
   reg  [7:0]  interrupt_pending_flags;
   reg         global_interrupt_enable;
   reg  [1:0]  power_mode;
   reg  [7:0]  aw_addr;
   reg         aw_held;
   reg  [31:0] w_data;
   reg  [3:0]  w_strb;
   reg         w_held;
   reg  [4:0]  evt_last;
   wire [4:0]  evt_sync;
   wire [4:0]  evt_rise;
   wire [7:0]  evt_bits;
   wire [7:0]  hit;
   wire        sleeping;
   wire        do_write;
   reg  [9:0]  next_vector;
   wire [9:0]  vec_tab [0:4];

   assign vec_tab[0] = `TPW_VEC_CNT_A;
   assign vec_tab[1] = `TPW_VEC_CNT_B;
   assign vec_tab[2] = `TPW_VEC_CNT_C;
   assign vec_tab[3] = `TPW_VEC_HIGH;
   assign vec_tab[4] = `TPW_VEC_LOW;

   // ==========================================================
   // event capture
   tpw_sync #(.WIDTH(5)) u_sync (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .async_in (timer_event),
      .sync_out (evt_sync)
   );

   always @(posedge aclk) begin
      if (!aresetn) begin
         evt_last <= 5'h00;
      end else begin
         evt_last <= evt_sync;
      end
   end

   assign evt_rise = evt_sync & ~evt_last;
   assign evt_bits = {evt_rise, 3'h0};
   assign sleeping = (power_mode == `TPW_MODE_SLEEP);
   // enabled events only; sleep masks them since the timers are halted
   assign hit = evt_bits & timer_source_interrupt_enable &
                {8{~sleeping}};

   // ==========================================================
   // axi write channel: address and data taken in either order
   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
   assign do_write      = aw_held & w_held & ~s_axi_bvalid;

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= 8'h00;
         w_data       <= 32'h0000_0000;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (aw_addr == `TPW_ADDR_ENABLE ||
                aw_addr == `TPW_ADDR_PENDING ||
                aw_addr == `TPW_ADDR_CONTROL ||
                aw_addr == `TPW_ADDR_STATUS) begin
               s_axi_bresp <= 2'h0;
            end else begin
               s_axi_bresp <= 2'h2; // slverr on unmapped address
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ==========================================================
   // enable and control registers
   always @(posedge aclk) begin
      if (!aresetn) begin
         timer_source_interrupt_enable <= `TPW_RST_ENABLE;
         global_interrupt_enable       <= 1'b0;
         power_mode                    <= `TPW_MODE_NORMAL;
      end else begin
         if (do_write && w_strb[0]) begin
            if (aw_addr == `TPW_ADDR_ENABLE) begin
               timer_source_interrupt_enable <= w_data[7:0] &
                                                `TPW_SRC_MASK;
            end else if (aw_addr == `TPW_ADDR_CONTROL) begin
               global_interrupt_enable <= w_data[`TPW_CTL_GIE];
               power_mode <= w_data[`TPW_CTL_MODE_MSB:`TPW_CTL_MODE_LSB];
            end
         end
         // an idle core woken by any enabled source returns to normal
         if (|hit && power_mode == `TPW_MODE_IDLE) begin
            power_mode <= `TPW_MODE_NORMAL;
         end
      end
   end

   // ==========================================================
   // pending flags: write one to clear, a new event wins over the clear
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_pend
         always @(posedge aclk) begin
            if (!aresetn) begin
               interrupt_pending_flags[gi] <= 1'b0;
            end else if (hit[gi]) begin
               interrupt_pending_flags[gi] <= 1'b1;
            end else if (do_write && w_strb[0] &&
                         aw_addr == `TPW_ADDR_PENDING &&
                         w_data[gi]) begin
               interrupt_pending_flags[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // ==========================================================
   // vector selection, lowest source bit has priority
   integer k;
   always @* begin
      next_vector = 10'h000;
      for (k = 4; k >= 0; k = k - 1) begin
         if (hit[k+3]) begin
            next_vector = vec_tab[k];
         end
      end
   end

   // ==========================================================
   // core sequencer outputs
   always @(posedge aclk) begin
      if (!aresetn) begin
         wake_core        <= 1'b0;
         next_instr_pulse <= 1'b0;
         vector_req       <= 1'b0;
         vector_addr      <= 10'h000;
      end else begin
         wake_core <= |hit && power_mode == `TPW_MODE_IDLE;
         next_instr_pulse <= |hit && !global_interrupt_enable;
         if (|hit && global_interrupt_enable && !vector_req) begin
            vector_req  <= 1'b1;
            vector_addr <= next_vector;
         end else if (vector_req && vector_ack) begin
            vector_req <= 1'b0;
         end
      end
   end

   // ==========================================================
   // clock gating requests per power mode
   always @(posedge aclk) begin
      if (!aresetn) begin
         osc_run           <= 1'b1;
         main_counters_run <= 1'b1;
         pulse_gen_run     <= 1'b1;
      end else begin
         osc_run           <= ~sleeping;
         main_counters_run <= ~sleeping;
         pulse_gen_run     <= ~sleeping;
      end
   end

   // ==========================================================
   // axi read channel
   assign s_axi_arready = ~s_axi_rvalid;

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= 2'h0;
         if (s_axi_araddr == `TPW_ADDR_ENABLE) begin
            s_axi_rdata <= {24'h0, timer_source_interrupt_enable};
         end else if (s_axi_araddr == `TPW_ADDR_PENDING) begin
            s_axi_rdata <= {24'h0, interrupt_pending_flags};
         end else if (s_axi_araddr == `TPW_ADDR_CONTROL) begin
            s_axi_rdata <= {29'h0, power_mode, global_interrupt_enable};
         end else if (s_axi_araddr == `TPW_ADDR_STATUS) begin
            s_axi_rdata <= {20'h0, vector_req, vector_addr, wake_core};
         end else begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule // tpw_router

// ### tpw_router_sva.sv
// assertions on the core-side outputs of the timer event router.
// assumes the events are driven as clean levels on the aclk edge.
module tpw_router_sva (
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire logic [4:0] timer_event,
   input wire logic       wake_core,
   input wire logic       next_instr_pulse,
   input wire logic       vector_req,
   input wire logic [9:0] vector_addr,
   input wire logic       vector_ack,
   input wire logic       osc_run,
   input wire logic       main_counters_run,
   input wire logic       pulse_gen_run
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] prev_ev;
   logic [3:0] since;
   // ==========================================================
   // cycles since the last rising event, saturating at 15
   always @(posedge aclk) begin
      prev_ev <= timer_event;
      if (!aresetn)
         since <= 4'hf;
      else if (|(timer_event & ~prev_ev))
         since <= 4'h0;
      else if (since != 4'hf)
         since <= since + 4'h1;
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wake_runs_a:
      assert property (wake_core |-> osc_run && pulse_gen_run &&
         main_counters_run)
         else $error("wake while generators stopped");
   run_agree_a:
      assert property (osc_run == main_counters_run &&
         osc_run == pulse_gen_run) else $error("run outputs disagree");
   sleep_quiet_a:
      assert property (!osc_run |-> !wake_core && !next_instr_pulse &&
         !$rose(vector_req)) else $error("activity in sleep");
   next_excl_a:
      assert property (next_instr_pulse |-> !$rose(vector_req))
         else $error("next and vector together");
   vec_hold_a:
      assert property (vector_req && !vector_ack |=> vector_req &&
         $stable(vector_addr)) else $error("vector dropped early");
   vec_addr_a:
      assert property ($rose(vector_req) |-> vector_addr inside
         {10'h012, 10'h015, 10'h018, 10'h01b, 10'h01e})
         else $error("bad vector address");
   pulse_once_a:
      assert property (next_instr_pulse || wake_core |=>
         !next_instr_pulse && !wake_core) else $error("pulse too long");
   ev_latency_a:
      assert property (next_instr_pulse || $rose(vector_req) |->
         since >= 4'h1 && since <= 4'h6) else $error("response not timely");
endmodule // tpw_router_sva

bind tpw_router tpw_router_sva u_sva (.aclk(aclk), .aresetn(aresetn),
   .timer_event(timer_event), .wake_core(wake_core),
   .next_instr_pulse(next_instr_pulse), .vector_req(vector_req),
   .vector_addr(vector_addr), .vector_ack(vector_ack), .osc_run(osc_run),
   .main_counters_run(main_counters_run), .pulse_gen_run(pulse_gen_run));

// ### tpw_sync.v
// two-flop synchroniser for a vector of event pulses from the timers.
// assumes the timers hold each event level at least two aclk cycles.
module tpw_sync #(
   parameter WIDTH = 5
) (
   input  wire             aclk,
   input  wire             aresetn,
   input  wire [WIDTH-1:0] async_in,
   output reg  [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] meta;

   // ==========================================================
   // first stage is read only by the second stage
   always @(posedge aclk) begin
      if (!aresetn) begin
         meta     <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end
endmodule // tpw_sync
